/* core/dsi_pkg.sv */
// shared constants and types for the serial input port of the current-output converter
package dsi_pkg;

	// word and frame layout
	localparam int WORD_W         = 16;
	localparam int FRAME_BITS     = WORD_W + 2;
	localparam int BYTE_W         = 8;

	// asynchronous receiver timing, in serial clocks
	localparam int CELL_CLKS      = 16;
	localparam int FIRST_SAMPLE   = 24;
	localparam int STOP_SAMPLE    = FIRST_SAMPLE + CELL_CLKS * WORD_W;
	localparam int RX_CNT_W       = 9;
	localparam logic [3:0] SAMPLE_PHASE = 4'(FIRST_SAMPLE % CELL_CLKS);

	// asynchronous mode limits
	localparam int OVERSAMPLE     = 16;
	localparam int MAX_RATE_BPS   = 150_000;
	localparam int MAX_ACLK_HZ    = MAX_RATE_BPS * OVERSAMPLE;

	// system clock and host serial clock timing
	localparam int CLK_NS         = 25;
	localparam int SCLK_HALF_NS   = 250;
	localparam int SCLK_HALF_CYC  = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
	localparam int DIV_W          = 8;

	// reset values
	localparam logic [15:0] CODE_RST = 16'h0000;
	localparam logic [15:0] SR_RST   = 16'h0000;

	// asynchronous receiver states
	typedef enum logic [2:0] {
		DSI_RX_IDLE = 3'b001,
		DSI_RX_RUN  = 3'b010,
		DSI_RX_ERR  = 3'b100
	} dsi_rx_t;

	// host sequencer states
	typedef enum logic [4:0] {
		DSI_H_IDLE  = 5'b00001,
		DSI_H_LEAD  = 5'b00010,
		DSI_H_SHIFT = 5'b00100,
		DSI_H_LATCH = 5'b01000,
		DSI_H_ATX   = 5'b10000
	} dsi_host_t;

endpackage

/* core/dsi_link_if.sv */
// link wires between the serial master and the converter's input port
`timescale 1ns/1ps
`default_nettype none
interface dsi_link_if;
	logic sclk;
	logic sdi;
	logic latch_drv;
	logic latch_oe;
	logic sdo;
	logic latch;

	// pull-up on the strobe line when the master does not drive it
	assign latch = latch_oe ? latch_drv : 1'b1;

	modport host (output sclk, output sdi, output latch_drv, output latch_oe, input sdo);
	modport dev  (input sclk, input sdi, input latch, output sdo);
endinterface
`default_nettype wire

/* core/dsi_dev.sv */
// converter end: three-wire shift/latch input, daisy-chain output and framed asynchronous receiver
//
// How it works
// - three-wire: shift data on serial clock rise
// - strobe copies shift register to converter latch
// - host keeps clock still during strobe
// - 16-bit shift register, overflow to serial out
// - two chained devices take 32 bits
// - shared strobe loads every chained device
// - strobe held high selects asynchronous mode
// - async clock is sixteen times bit rate
// - async rate up to 150 kbit/s
// - strobe driven low before first byte
// - upper byte then lower byte, rising edges
// - strobe driven high after second byte
// - code zero gives lowest output
// - all-ones code gives full scale minus LSB
// - async word framed by start 0, stop 1
// - sample MSB at clock 24, then every 16
// - bad stop: one-clock pulse out, no update
// - idle line held high between words
`timescale 1ns/1ps
`default_nettype none
module dsi_dev (
	// clock and reset
	input  wire logic                         clk_i,
	input  wire logic                         nrst_i,
	// link
	dsi_link_if.dev                           link,
	// converter side
	output logic [dsi_pkg::WORD_W-1:0]        dac_code_o,
	output logic                              dac_load_o,
	output logic                              frame_err_o,
	output logic                              async_mode_o
);
	import dsi_pkg::*;

	// true on an async clock count that falls at a data or stop cell centre
	// the stop centre matches as well, so the receiver tests for it first
	function automatic logic is_cell_centre(input logic [RX_CNT_W-1:0] c);
		is_cell_centre = (c >= RX_CNT_W'(FIRST_SAMPLE)) && (c[3:0] == SAMPLE_PHASE);
	endfunction

	// pin synchronisers, two flops each
	logic [1:0] sclk_s_q, sclk_s_d;
	logic [1:0] sdi_s_q, sdi_s_d;
	logic [1:0] lat_s_q, lat_s_d;

	// newest pin level enters at bit 0, only bit 1 feeds logic
	always_comb begin
		sclk_s_d = {sclk_s_q[0], link.sclk};
		sdi_s_d  = {sdi_s_q[0], link.sdi};
		lat_s_d  = {lat_s_q[0], link.latch};
	end

	// reset to the idle level of each line: clock low, data and strobe high
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sclk_s_q <= 2'b00;
			sdi_s_q  <= 2'b11; // line idles high
			lat_s_q  <= 2'b11; // pull-up level, no false strobe edge
		end else begin
			sclk_s_q <= sclk_s_d;
			sdi_s_q  <= sdi_s_d;
			lat_s_q  <= lat_s_d;
		end
	end

	// synchronised pin levels
	logic sclk_l;
	logic sdi_l;
	logic lat_l;
	assign sclk_l = sclk_s_q[1];
	assign sdi_l  = sdi_s_q[1];
	assign lat_l  = lat_s_q[1];

	// state
	logic [WORD_W-1:0]   sr_q, sr_d;
	logic [WORD_W-1:0]   code_q, code_d;
	logic                load_q, load_d;
	logic                err_q, err_d;
	logic                async_q, async_d;
	logic                sdo_q, sdo_d;
	logic                sclk_p_q, sclk_p_d;
	logic                lat_p_q, lat_p_d;
	logic                sdi_p_q, sdi_p_d;
	logic [RX_CNT_W-1:0] cnt_q, cnt_d;
	dsi_rx_t             rx_q, rx_d;

	// edge events on the synchronised pins
	// previous levels are kept in flops beside the state
	logic sclk_rise;
	logic lat_rise;
	logic [RX_CNT_W-1:0] cnt_nx;
	assign sclk_rise = sclk_l & ~sclk_p_q;
	assign lat_rise  = lat_l & ~lat_p_q;
	assign cnt_nx    = cnt_q + RX_CNT_W'(1);

	// next-state logic for both modes
	always_comb begin
		sr_d     = sr_q;
		code_d   = code_q;
		load_d   = 1'b0;
		err_d    = 1'b0;
		async_d  = async_q;
		sdo_d    = sdo_q;
		sclk_p_d = sclk_l;
		lat_p_d  = lat_l;
		sdi_p_d  = sdi_p_q;
		cnt_d    = cnt_q;
		rx_d     = rx_q;

		// strobe rise in three-wire mode; clock assumed still here
		// in async mode the strobe only idles high, so a rise is ignored
		if (lat_rise && !async_q) begin
			code_d = sr_q;
			load_d = 1'b1;
		end

		// mode follows the strobe level at each clock rise:
		// low means three-wire shifting, high means the framed receiver
		if (sclk_rise && !lat_l) begin
			// three-wire shift, bit moving into the top goes downstream
			async_d = 1'b0;
			sr_d    = {sr_q[WORD_W-2:0], sdi_l};
			sdo_d   = sr_q[WORD_W-2];
			rx_d    = DSI_RX_IDLE;
		end else if (sclk_rise && lat_l) begin
			// strobe high while clock runs: oversampled framed receiver
			async_d = 1'b1;
			sdi_p_d = sdi_l;
			sdo_d   = 1'b0;
			case (rx_q)
				DSI_RX_IDLE: begin
					// start edge; this rise is clock 1 of the start cell
					if (sdi_p_q && !sdi_l) begin
						cnt_d = RX_CNT_W'(1);
						rx_d  = DSI_RX_RUN;
					end
				end
				DSI_RX_RUN: begin
					// the count moves on serial clock rises only
					cnt_d = cnt_nx;
					if (cnt_nx == RX_CNT_W'(STOP_SAMPLE)) begin
						// stop cell centre
						if (sdi_l) begin
							code_d = sr_q;
							load_d = 1'b1;
							rx_d   = DSI_RX_IDLE;
						end else begin
							err_d = 1'b1;
							rx_d  = DSI_RX_ERR;
						end
					end else if (is_cell_centre(cnt_nx)) begin
						sr_d = {sr_q[WORD_W-2:0], sdi_l};
					end
				end
				DSI_RX_ERR: begin
					// one clock period wide pulse after the bad stop
					sdo_d = 1'b1;
					rx_d  = DSI_RX_IDLE;
				end
				default: begin
					rx_d = DSI_RX_IDLE;
				end
			endcase
		end
	end

	// registers
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sr_q     <= SR_RST;
			code_q   <= CODE_RST;
			load_q   <= 1'b0;
			err_q    <= 1'b0;
			async_q  <= 1'b0;
			sdo_q    <= 1'b0;
			sclk_p_q <= 1'b0;
			lat_p_q  <= 1'b1; // matches the strobe synchroniser reset
			sdi_p_q  <= 1'b1;
			cnt_q    <= '0;
			rx_q     <= DSI_RX_IDLE;
		end else begin
			sr_q     <= sr_d;
			code_q   <= code_d;
			load_q   <= load_d;
			err_q    <= err_d;
			async_q  <= async_d;
			sdo_q    <= sdo_d;
			sclk_p_q <= sclk_p_d;
			lat_p_q  <= lat_p_d;
			sdi_p_q  <= sdi_p_d;
			cnt_q    <= cnt_d;
			rx_q     <= rx_d;
		end
	end

	// outputs straight from flops
	// serial out idles low in async mode, high only for a framing error
	assign link.sdo     = sdo_q;
	assign dac_code_o   = code_q;
	assign dac_load_o   = load_q;
	assign frame_err_o  = err_q;
	assign async_mode_o = async_q;

endmodule
`default_nettype wire

/* core/dsi_host.sv */
// serial master end: three-wire word writer and framed asynchronous transmitter
`timescale 1ns/1ps
`default_nettype none
module dsi_host #(
	parameter int HALF_CYC = dsi_pkg::SCLK_HALF_CYC
) (
	// clock and reset
	input  wire logic                         clk_i,
	input  wire logic                         nrst_i,
	// user side
	input  wire logic [dsi_pkg::WORD_W-1:0]   word_i,
	input  wire logic                         send_i,
	input  wire logic                         async_i,
	output logic                              busy_o,
	output logic                              done_o,
	// link
	dsi_link_if.host                          link
);
	import dsi_pkg::*;

	// state
	dsi_host_t             st_q, st_d;
	logic [DIV_W-1:0]      div_q, div_d;
	logic [FRAME_BITS-1:0] sh_q, sh_d;
	logic [4:0]            bit_q, bit_d;
	logic [3:0]            sub_q, sub_d;
	logic                  sclk_q, sclk_d;
	logic                  sdi_q, sdi_d;
	logic                  lat_q, lat_d;
	logic                  oe_q, oe_d;
	logic                  busy_q, busy_d;
	logic                  done_q, done_d;

	// half-period tick of the serial clock divider
	logic tick;
	assign tick = (div_q == DIV_W'(HALF_CYC - 1));

	// next-state logic
	always_comb begin
		st_d   = st_q;
		div_d  = tick ? '0 : div_q + DIV_W'(1);
		sh_d   = sh_q;
		bit_d  = bit_q;
		sub_d  = sub_q;
		sclk_d = sclk_q;
		sdi_d  = sdi_q;
		lat_d  = lat_q;
		oe_d   = !async_i;
		busy_d = busy_q;
		done_d = 1'b0;

		// async clock runs free, line idles high
		if (async_i && tick) begin
			sclk_d = !sclk_q;
		end

		case (st_q)
			DSI_H_IDLE: begin
				busy_d = 1'b0;
				if (async_i) begin
					sdi_d = 1'b1;
					// start only on a falling clock edge
					if (send_i && tick && sclk_q) begin
						sh_d   = {1'b0, word_i, 1'b1};
						sdi_d  = 1'b0;
						bit_d  = '0;
						sub_d  = '0;
						busy_d = 1'b1;
						st_d   = DSI_H_ATX;
					end
				end else begin
					lat_d  = 1'b1;
					sclk_d = 1'b0;
					if (send_i) begin
						sh_d   = {word_i, 2'b00};
						lat_d  = 1'b0;
						sdi_d  = word_i[WORD_W-1];
						bit_d  = '0;
						div_d  = '0;
						busy_d = 1'b1;
						st_d   = DSI_H_LEAD;
					end
				end
			end
			DSI_H_LEAD: begin
				// strobe low for one full period before the first rising edge
				if (tick) begin
					st_d = DSI_H_SHIFT;
				end
			end
			DSI_H_SHIFT: begin
				// upper byte then lower byte, data valid at rising edge
				if (tick) begin
					sclk_d = !sclk_q;
					if (sclk_q) begin
						sh_d  = sh_q << 1;
						sdi_d = sh_q[FRAME_BITS-2];
						bit_d = bit_q + 5'd1;
						if (bit_q == 5'(WORD_W - 1)) begin
							st_d = DSI_H_LATCH;
						end
					end
				end
			end
			DSI_H_LATCH: begin
				// clock held low, strobe raised to load the word
				lat_d = 1'b1;
				if (tick) begin
					done_d = 1'b1;
					st_d   = DSI_H_IDLE;
				end
			end
			DSI_H_ATX: begin
				// change the line on falling edges, 16 clocks per cell
				if (tick && sclk_q) begin
					sub_d = sub_q + 4'd1;
					if (sub_q == 4'(CELL_CLKS - 1)) begin
						sh_d  = sh_q << 1;
						bit_d = bit_q + 5'd1;
						if (bit_q == 5'(FRAME_BITS - 1)) begin
							sdi_d  = 1'b1;
							done_d = 1'b1;
							st_d   = DSI_H_IDLE;
						end else begin
							sdi_d = sh_q[FRAME_BITS-2];
						end
					end
				end
				if (!async_i) begin
					st_d = DSI_H_IDLE;
				end
			end
			default: begin
				st_d = DSI_H_IDLE;
			end
		endcase
	end

	// registers
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_q   <= DSI_H_IDLE;
			div_q  <= '0;
			sh_q   <= '0;
			bit_q  <= '0;
			sub_q  <= '0;
			sclk_q <= 1'b0;
			sdi_q  <= 1'b1;
			lat_q  <= 1'b1;
			oe_q   <= 1'b0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			st_q   <= st_d;
			div_q  <= div_d;
			sh_q   <= sh_d;
			bit_q  <= bit_d;
			sub_q  <= sub_d;
			sclk_q <= sclk_d;
			sdi_q  <= sdi_d;
			lat_q  <= lat_d;
			oe_q   <= oe_d;
			busy_q <= busy_d;
			done_q <= done_d;
		end
	end

	// outputs straight from flops
	assign link.sclk      = sclk_q;
	assign link.sdi       = sdi_q;
	assign link.latch_drv = lat_q;
	assign link.latch_oe  = oe_q;
	assign busy_o         = busy_q;
	assign done_o         = done_q;

endmodule
`default_nettype wire

/* dv/dsi_checker.sv */
// link assertions for the master and near converter input
`timescale 1ns/1ps
`default_nettype none
module dsi_checker (
	// clock and reset
	input wire logic                       clk_i,
	input wire logic                       nrst_i,
	// link and converter status
	input wire logic                       sclk,
	input wire logic                       sdi,
	input wire logic                       latch_drv,
	input wire logic                       latch_oe,
	input wire logic                       latch,
	input wire logic                       sdo,
	input wire logic [dsi_pkg::WORD_W-1:0] dac_code_o,
	input wire logic                       dac_load_o,
	input wire logic                       async_mode_o
);
	import dsi_pkg::*;
	// fewest clk cycles per async clock period at the top rate
	localparam int MIN_PER = (1_000_000_000 / CLK_NS + MAX_ACLK_HZ - 1) / MAX_ACLK_HZ;
	logic [WORD_W-1:0] sr_q;
	logic [WORD_W-1:0] exp_q;
	logic [8:0]        acnt_q;
	logic [4:0]        tcnt_q;
	logic              run_q;
	logic              sclk_q;
	logic [7:0]        per_q;
	logic              rise;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	// clock rise seen on the pin
	assign rise = sclk && !sclk_q;
	// shadow shift register, bits per word, rises since a start edge
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sr_q   <= '0;
			exp_q  <= '0;
			acnt_q <= '0;
			tcnt_q <= '0;
			run_q  <= 1'b0;
			sclk_q <= 1'b0;
			per_q  <= 8'hff;
		end else begin
			sclk_q <= sclk;
			// clk cycles since the last serial clock rise, saturating
			if (rise) begin
				per_q <= 8'h01;
			end else if (per_q != 8'hff) begin
				per_q <= per_q + 8'h01;
			end
			if (rise && !latch) begin
				sr_q <= {sr_q[WORD_W-2:0], sdi};
			end
			if ($fell(latch_drv)) begin
				tcnt_q <= '0;
			end else if (rise && !latch) begin
				tcnt_q <= tcnt_q + 5'h01;
			end
			if ($rose(latch_drv)) begin
				exp_q <= sr_q;
			end
			if (!latch_oe && !run_q && $fell(sdi)) begin
				run_q  <= 1'b1;
				acnt_q <= '0;
			end else if (run_q && rise) begin
				run_q  <= acnt_q != 9'h11f;
				acnt_q <= (acnt_q == 9'h11f) ? 9'h000 : acnt_q + 9'h001;
			end
		end
	end
	a_strobe_low_shift: assert property (latch_oe && $rose(sclk) |-> !latch_drv)
		else $error("clock rose with strobe high");
	a_clock_still_latch: assert property (latch_oe && $changed(latch_drv) |-> !sclk && $stable(sclk))
		else $error("clock moved at strobe edge");
	a_latch_after_word: assert property (latch_oe && $rose(latch_drv) |-> tcnt_q == 5'h10)
		else $error("strobe not after sixteen bits");
	a_code_from_shift: assert property (dac_load_o && !async_mode_o |=> dac_code_o == exp_q)
		else $error("loaded code differs from shifted bits");
	a_chain_output: assert property ((!async_mode_o && !latch && $stable(sr_q)) [*8] |-> sdo == sr_q[WORD_W-1])
		else $error("serial out not the oldest bit");
	a_async_select: assert property (latch && $rose(sclk) |-> ##[1:6] async_mode_o)
		else $error("no async mode with strobe high");
	a_bit_cell: assert property (run_q && $changed(sdi) |-> acnt_q[3:0] == 4'h0)
		else $error("data edge inside a bit cell");
	a_async_stop: assert property (dac_load_o && async_mode_o |-> acnt_q == 9'h118)
		else $error("async load not at stop sample");
	a_async_rate: assert property (!latch_oe && rise |-> per_q >= 8'(MIN_PER))
		else $error("async clock faster than the rate limit");
endmodule
`default_nettype wire

/* dv/testbench.sv */
// bench: master, near input chained to a far input, framed words into the far one
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import dsi_pkg::*;
	localparam int LIMIT = 40000;
	logic              clk_i = 1'b0;
	logic              nrst_i = 1'b0;
	logic [WORD_W-1:0] word_i = '0;
	logic              send_i = 1'b0;
	logic              async_i = 1'b0;
	logic              b_own = 1'b0;
	logic              b_sclk = 1'b0;
	logic              b_sdi = 1'b1;
	logic              busy_o, done_o, load_a, load_b, err_a, err_b, mode_a, mode_b;
	logic [WORD_W-1:0] code_a, code_b;
	int                num_errors = 0, checks = 0, cyc = 0, n_load = 0, n_err = 0, n_sdo = 0, n_err_a = 0;
	logic [WORD_W-1:0] words [4] = '{16'hffff, 16'h0000, 16'h5a3c, 16'ha5c3};
	logic [WORD_W-1:0] frm [3] = '{16'h1234, 16'hbeef, 16'h0f0f};
	logic [2:0]        stp = 3'h5;

	initial forever #12.5 clk_i = ~clk_i;

	dsi_link_if link_a ();
	dsi_link_if link_b ();
	// far input: chained behind the near one, or bit-banged
	assign link_b.sclk      = b_own ? b_sclk : link_a.sclk;
	assign link_b.sdi       = b_own ? b_sdi : link_a.sdo;
	assign link_b.latch_oe  = b_own ? 1'b0 : link_a.latch_oe;
	assign link_b.latch_drv = link_a.latch_drv;

	dsi_host u_dsi_host (.clk_i(clk_i), .nrst_i(nrst_i), .word_i(word_i), .send_i(send_i),
		.async_i(async_i), .busy_o(busy_o), .done_o(done_o), .link(link_a.host));
	dsi_dev u_dsi_dev (.clk_i(clk_i), .nrst_i(nrst_i), .link(link_a.dev), .dac_code_o(code_a),
		.dac_load_o(load_a), .frame_err_o(err_a), .async_mode_o(mode_a));
	dsi_dev u_dsi_dev_b (.clk_i(clk_i), .nrst_i(nrst_i), .link(link_b.dev), .dac_code_o(code_b),
		.dac_load_o(load_b), .frame_err_o(err_b), .async_mode_o(mode_b));
	dsi_checker u_dsi_checker (.clk_i(clk_i), .nrst_i(nrst_i), .sclk(link_a.sclk), .sdi(link_a.sdi),
		.latch_drv(link_a.latch_drv), .latch_oe(link_a.latch_oe), .latch(link_a.latch), .sdo(link_a.sdo),
		.dac_code_o(code_a), .dac_load_o(load_a), .async_mode_o(mode_a));

	// far-end tallies, near error tally and hang guard
	always @(posedge clk_i) begin
		n_load <= n_load + int'(load_b);
		n_err  <= n_err + int'(err_b);
		n_err_a <= n_err_a + int'(err_a);
		n_sdo  <= n_sdo + int'(link_b.sdo === 1'b1);
		cyc    <= cyc + 1;
		if (cyc == LIMIT) begin
			num_errors++;
			give_verdict();
		end
	end

	task automatic chk(input string what, input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// request held until taken, then wait for the end pulse
	task automatic put_word(input logic [WORD_W-1:0] w);
		int n;
		n = 0;
		word_i <= w;
		send_i <= 1'b1;
		while (busy_o !== 1'b1 && n < 2000) begin
			@(posedge clk_i);
			n++;
		end
		send_i <= 1'b0;
		while (done_o !== 1'b1 && n < 12000) begin
			@(posedge clk_i);
			n++;
		end
		chk("done", 16'(done_o), 16'h0001);
		repeat (8) @(posedge clk_i);
	endtask

	// twenty cells of sixteen clocks, data set on the falling clock, at the master's clock rate
	task automatic bang(input logic [19:0] f);
		for (int i = 0; i < 320; i++) begin
			repeat (SCLK_HALF_CYC) @(posedge clk_i);
			b_sclk <= 1'b0;
			if (i % 16 == 0) b_sdi <= f[19 - i / 16];
			repeat (SCLK_HALF_CYC) @(posedge clk_i);
			b_sclk <= 1'b1;
		end
	endtask

	task automatic give_verdict();
		if (num_errors == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		logic [WORD_W-1:0] prev;
		int                e0, s0, l0;
		prev = '0;
		repeat (20) @(posedge clk_i);
		nrst_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		// three-wire words: near keeps the last, far the one before
		for (int i = 0; i < 4; i++) begin
			put_word(words[i]);
			chk("near code", code_a, words[i]);
			chk("far code", code_b, prev);
			prev = words[i];
		end
		chk("near mode", 16'(mode_a), 16'h0000);
		// framed words into the far input, the middle one with a bad stop bit
		b_own <= 1'b1;
		prev = words[2];
		for (int i = 0; i < 3; i++) begin
			e0 = n_err;
			s0 = n_sdo;
			l0 = n_load;
			bang({2'b10, frm[i], stp[i], 1'b1});
			if (stp[i]) prev = frm[i];
			chk("far code", code_b, prev);
			chk("far errors", 16'(n_err - e0), 16'(!stp[i]));
			chk("far loads", 16'(n_load - l0), 16'(stp[i]));
			chk("far pulse", 16'(n_sdo - s0), stp[i] ? 16'h0000 : 16'(2 * SCLK_HALF_CYC));
		end
		chk("far mode", 16'(mode_b), 16'h0001);
		// framed word from the master to the near input
		async_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		put_word(16'hc35a);
		chk("near code", code_a, 16'hc35a);
		chk("near mode", 16'(mode_a), 16'h0001);
		chk("near errors", 16'(n_err_a), 16'h0000);
		give_verdict();
	end
endmodule
`default_nettype wire
